// file: include/twi_pkg.sv
package twi_pkg;
  // ---------------------------------------------------------------
  // Register map (byte addresses, byte address = word index * 4)
  // ---------------------------------------------------------------
  localparam logic [4:0] ADDR_TXBUF  = 5'h00;
  localparam logic [4:0] ADDR_RXBUF  = 5'h04;
  localparam logic [4:0] ADDR_BAUD   = 5'h08;
  localparam logic [4:0] ADDR_MODE   = 5'h0C;
  localparam logic [4:0] ADDR_SMA    = 5'h10;
  localparam logic [4:0] ADDR_SMB    = 5'h14;
  localparam logic [4:0] ADDR_SMC    = 5'h18;
  localparam logic [4:0] ADDR_SMD    = 5'h1C;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam logic [2:0] MODE_TWO_WIRE = 3'h2;
  localparam int SMA_SEL   = 0;
  localparam int SMA_ABC   = 1;
  localparam int SMA_BUSY  = 2;
  localparam int SMB_LAYOUT = 0;
  localparam int SMB_CSC   = 1;
  localparam int SMB_WAIT  = 2;
  localparam int SMB_ALS   = 3;
  localparam int SMB_STC   = 4;
  localparam int SMB_FLOW  = 5;
  localparam int SMB_DOD   = 6;
  localparam int SMC_PHASE = 1;
  localparam int SMC_DL    = 5;
  localparam int SMD_STA   = 0;
  localparam int SMD_RSTA  = 1;
  localparam int SMD_STP   = 2;
  localparam int SMD_GEN   = 3;
  localparam int SMD_ACK_DATA_VALUE  = 4;
  localparam int SMD_ACK_OUTPUT_ENABLE  = 5;
  localparam int SMD_RELS  = 6;
  localparam int SMD_HOLD9 = 7;
  localparam int RX_ALOST  = 11;
  localparam logic [7:0] BAUD_RESET = 8'h00;
  // ---------------------------------------------------------------
  // Event strobes
  // ---------------------------------------------------------------
  typedef struct packed {
    logic condition;
    logic nack;
    logic ack;
  } event_type;
endpackage

// file: design/twi_unit.sv
`timescale 1ns/1ps
// Notes on behaviour
// (R1) Active only with mode 010 and two-wire select
// (R2) Start/stop detection share one request line
// (R3) Request bits generate start, restart, stop
// (R4) Software sets start before generator select
// (R5) Generator select picks detect or completion timing
// (R6) Compare sent bit with bus at clock rise
// (R7) Per-bit arbitration flag set or cleared
// (R8) Per-byte arbitration flag set at ninth fall
// (R9) Software clears per-byte flag between bytes
// (R10) Loss stops data drive when enabled
// (R11) Clock pin fall resets internal clock low
// (R12) Counter pauses while pin low in the internal high phase; clock is AND
// (R13) Clock wait holds line low at ninth fall
// (R14) Stop releases clock line when enabled
// (R15) Forced clock low while bit set
// (R16) Phase plus hold bit holds low after ninth
// (R17) Eight bits MSB first then ack bit
// (R18) Data output delay none or 2 to 8
// (R19) Data output disable tri-states data line
// (R20) Receive layout selects buffer bit placement
// (R21) Ack output bit drives ack value
// (R22) Ninth rise raises ack or nack request with receive layout 0
// (R23) Start resets shifters and sets clock wait
module twi_unit
  import twi_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [4:0]  regAddr,
  input  wire logic [15:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [15:0] regRdata,
  input  wire logic        sclIn,
  output logic             sclOut,
  output logic             sclOe,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  output event_type        events,
  output logic             dmaReq
);
  // ---------------------------------------------------------------
  // Pin synchronisers and edges
  // ---------------------------------------------------------------
  logic [1:0] sclSync_r, sdaSync_r;
  logic       sclD_r, sdaD_r;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sclSync_r <= 2'h3;
      sdaSync_r <= 2'h3;
      sclD_r    <= 1'b1;
      sdaD_r    <= 1'b1;
    end else begin
      sclSync_r <= {sclSync_r[0], sclIn};
      sdaSync_r <= {sdaSync_r[0], sdaIn};
      sclD_r    <= sclSync_r[1];
      sdaD_r    <= sdaSync_r[1];
    end
  end
  logic sclPin, sdaPin, pinFall, startDet, stopDet;
  assign sclPin   = sclSync_r[1];
  assign sdaPin   = sdaSync_r[1];
  assign pinFall  = sclD_r & ~sclPin;
  assign startDet = sclPin & sclD_r & sdaD_r & ~sdaPin; // R2
  assign stopDet  = sclPin & sclD_r & ~sdaD_r & sdaPin; // R2
  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [7:0] txBuf_r, baud_r, smA_r, smB_r, smC_r, smD_r;
  logic [2:0] mode_r;
  logic [8:0] rxBuf_r;
  logic       alost_r, active;
  logic       byteEnd, stcLoad, genDone;
  assign active = (mode_r == MODE_TWO_WIRE) & smA_r[SMA_SEL]; // R1
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      txBuf_r <= 8'h00;
      baud_r  <= BAUD_RESET;
      mode_r  <= 3'h0;
      smA_r   <= 8'h00;
      smB_r   <= 8'h00;
      smC_r   <= 8'h00;
      smD_r   <= 8'h00;
    end else begin
      if (regWr && regAddr == ADDR_TXBUF) txBuf_r <= regWdata[7:0];
      if (regWr && regAddr == ADDR_BAUD)  baud_r  <= regWdata[7:0];
      if (regWr && regAddr == ADDR_MODE)  mode_r  <= regWdata[2:0];
      if (regWr && regAddr == ADDR_SMA)
        smA_r <= {regWdata[7:3], smA_r[SMA_BUSY], regWdata[1:0]};
      if (regWr && regAddr == ADDR_SMC)   smC_r   <= regWdata[7:0];
      // Bus busy follows detected conditions
      if (startDet) smA_r[SMA_BUSY] <= 1'b1;
      else if (stopDet) smA_r[SMA_BUSY] <= 1'b0;
      // Hardware set of clock wait wins over software write
      if (regWr && regAddr == ADDR_SMB) smB_r <= regWdata[7:0];
      if (stcLoad) smB_r[SMB_WAIT] <= 1'b1; // R23
      if (regWr && regAddr == ADDR_SMD) smD_r <= regWdata[7:0];
      if (genDone) smD_r[2:0] <= 3'h0;
    end
  end
  // Read port, one cycle latency
  always_ff @(posedge clk) begin
    if (!rst_n) regRdata <= 16'h0000;
    else if (regRd) begin
      case (regAddr)
        ADDR_TXBUF: regRdata <= {8'h00, txBuf_r};
        ADDR_RXBUF: regRdata <= {4'h0, alost_r, 2'h0, rxBuf_r};
        ADDR_BAUD:  regRdata <= {8'h00, baud_r};
        ADDR_MODE:  regRdata <= {13'h0000, mode_r};
        ADDR_SMA:   regRdata <= {8'h00, smA_r};
        ADDR_SMB:   regRdata <= {8'h00, smB_r};
        ADDR_SMC:   regRdata <= {8'h00, smC_r};
        ADDR_SMD:   regRdata <= {8'h00, smD_r};
        default:    regRdata <= 16'h0000;
      endcase
    end
  end
  // ---------------------------------------------------------------
  // Internal clock generator with synchronisation
  // ---------------------------------------------------------------
  logic [7:0] cnt_r;
  logic       intScl_r, xferClk, xferD_r, xRise, xFall;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_r    <= 8'h00;
      intScl_r <= 1'b1;
    end else if (!active || !smB_r[SMB_CSC]) begin // Slave: pin clocks
      cnt_r    <= baud_r;
      intScl_r <= 1'b1;
    end else if (smB_r[SMB_CSC] && intScl_r && pinFall) begin
      intScl_r <= 1'b0; // R11
      cnt_r    <= baud_r; // R11
    end else if (intScl_r && !sclPin && smB_r[SMB_CSC]) begin
      cnt_r <= cnt_r; // R12
    end else if (cnt_r == 8'h00) begin
      cnt_r    <= baud_r;
      intScl_r <= ~intScl_r;
    end else begin
      cnt_r <= cnt_r - 8'h01;
    end
  end
  assign xferClk = intScl_r & sclPin; // R12
  always_ff @(posedge clk) begin
    if (!rst_n) xferD_r <= 1'b1;
    else        xferD_r <= xferClk;
  end
  assign xRise = xferClk & ~xferD_r;
  assign xFall = ~xferClk & xferD_r;
  // ---------------------------------------------------------------
  // Bit counter, shifters, arbitration
  // ---------------------------------------------------------------
  logic [3:0] bitCnt_r;
  logic [8:0] txSh_r, rxSh_r;
  logic       mism_r, ninthDone_r, txBit, skipFall_r;
  assign stcLoad = active & startDet & smB_r[SMB_STC];
  assign byteEnd = xFall & (bitCnt_r == 4'h8);
  assign txBit   = txSh_r[8];
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bitCnt_r <= 4'h0;
      txSh_r   <= 9'h1FF;
      rxSh_r   <= 9'h000;
      skipFall_r <= 1'b0;
    end else if (stcLoad) begin
      bitCnt_r <= 4'h0; // R23
      txSh_r   <= {txBuf_r, 1'b1}; // R23
      rxSh_r   <= 9'h000; // R23
      skipFall_r <= 1'b1;
    end else if (active) begin
      // The clock fall that ends a start condition carries no bit
      if (startDet) {bitCnt_r, skipFall_r} <= {4'h0, 1'b1};
      if (xRise) rxSh_r <= {rxSh_r[7:0], sdaPin};
      if (xFall && skipFall_r) skipFall_r <= 1'b0;
      else if (xFall) begin
        if (bitCnt_r == 4'h8) begin
          bitCnt_r <= 4'h0;
          txSh_r   <= {txBuf_r, 1'b1}; // R17
        end else begin
          bitCnt_r <= bitCnt_r + 4'h1;
          txSh_r   <= {txSh_r[7:0], 1'b1}; // R17
        end
      end
    end
  end
  // Arbitration check on each transfer clock rise while the data line is driven
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      alost_r <= 1'b0;
      mism_r  <= 1'b0;
    end else begin
      if (regWr && regAddr == ADDR_RXBUF) alost_r <= regWdata[RX_ALOST];
      if (active && xRise && sdaOe) begin // R6
        if (!smA_r[SMA_ABC]) alost_r <= (txBit != sdaPin); // R7
        else if (txBit != sdaPin) mism_r <= 1'b1;
      end
      if (active && byteEnd && smA_r[SMA_ABC]) begin
        if (mism_r) alost_r <= 1'b1; // R8
        mism_r <= 1'b0;
      end
    end
  end
  // Receive buffer layout and ack/nack events
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rxBuf_r <= 9'h000;
      events  <= '0;
      dmaReq  <= 1'b0;
      ninthDone_r <= 1'b0;
    end else begin
      events.nack <= 1'b0;
      events.ack  <= 1'b0;
      events.condition <= 1'b0;
      dmaReq      <= 1'b0;
      ninthDone_r <= active & xRise & (bitCnt_r == 4'h8);
      if (ninthDone_r) begin
        if (!smB_r[SMB_LAYOUT]) begin
          rxBuf_r <= {rxSh_r[0], rxSh_r[8:1]}; // R20
          events.nack <= rxSh_r[0]; // R22
          events.ack  <= ~rxSh_r[0]; // R22
          dmaReq      <= ~rxSh_r[0]; // R22
        end else begin
          rxBuf_r <= {rxSh_r[1], 1'b0, rxSh_r[8:2]}; // R20
        end
      end
      // Detect timing vs. generation timing
      if (active && (smD_r[SMD_GEN] ? genDone : (startDet | stopDet)))
        events.condition <= 1'b1; // R5
    end
  end
  // ---------------------------------------------------------------
  // Condition generator
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {GEN_IDLE, GEN_P1, GEN_P2, GEN_P3} gen_type;
  gen_type gst_r;
  logic [7:0] gcnt_r;
  logic       gSda_r, gScl_r, isStop_r;
  assign genDone = (gst_r == GEN_P3) && (gcnt_r == 8'h00);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gst_r <= GEN_IDLE;
      gcnt_r <= 8'h00;
      gSda_r <= 1'b1;
      gScl_r <= 1'b1;
      isStop_r <= 1'b0;
    end else begin
      gcnt_r <= (gcnt_r == 8'h00) ? baud_r : gcnt_r - 8'h01;
      case (gst_r)
        GEN_IDLE: begin
          if (active && smD_r[SMD_GEN] && |smD_r[2:0]) begin // R3
            gst_r    <= GEN_P1;
            gcnt_r   <= baud_r;
            isStop_r <= smD_r[SMD_STP];
            gSda_r   <= ~smD_r[SMD_STP];
            gScl_r   <= 1'b1;
          end
        end
        GEN_P1: if (gcnt_r == 8'h00) gst_r <= GEN_P2;
        GEN_P2: if (gcnt_r == 8'h00) begin
          gSda_r <= isStop_r; // R3
          gst_r  <= GEN_P3;
        end
        GEN_P3: if (gcnt_r == 8'h00) begin
          gScl_r <= isStop_r;
          gst_r  <= GEN_IDLE;
        end
        default: gst_r <= GEN_IDLE;
      endcase
    end
  end
  // ---------------------------------------------------------------
  // Data output delay line, counted in count-source cycles
  // ---------------------------------------------------------------
  logic [7:0] dly_r;
  logic       dataRaw, dataDly;
  logic [2:0] dl;
  assign dl = smC_r[SMC_DL +: 3];
  assign dataRaw = (!smD_r[SMD_GEN] && smD_r[SMD_ACK_OUTPUT_ENABLE] &&
                    bitCnt_r == 4'h8) ? smD_r[SMD_ACK_DATA_VALUE] : txBit; // R21
  always_ff @(posedge clk) begin
    if (!rst_n) dly_r <= 8'hFF;
    else        dly_r <= {dly_r[6:0], dataRaw};
  end
  // Code 0 means no delay; codes 1..7 give 2..8 cycles
  assign dataDly = (dl == 3'h0) ? dataRaw : dly_r[dl]; // R18
  // ---------------------------------------------------------------
  // Pin drivers (open drain: drive low only)
  // ---------------------------------------------------------------
  logic holdLow_r, startHold_r;
  always_ff @(posedge clk) begin
    if (!rst_n) holdLow_r <= 1'b0;
    else if (!active || stopDet) holdLow_r <= 1'b0;
    else if (byteEnd && (smB_r[SMB_WAIT] ||
             (smC_r[SMC_PHASE] && smD_r[SMD_HOLD9])))
      holdLow_r <= 1'b1; // R13 R16
    else if (!smB_r[SMB_WAIT] &&
             !(smC_r[SMC_PHASE] && smD_r[SMD_HOLD9]))
      holdLow_r <= 1'b0; // R16
  end
  // A generated start parks both lines low until the internal clock runs
  always_ff @(posedge clk) begin
    if (!rst_n) startHold_r <= 1'b0;
    else if (genDone) startHold_r <= ~isStop_r; // R3
    else if (!active || gst_r != GEN_IDLE || !intScl_r) startHold_r <= 1'b0;
  end
  logic relScl_r;
  always_ff @(posedge clk) begin
    if (!rst_n) relScl_r <= 1'b0;
    else if (stopDet && smD_r[SMD_RELS]) relScl_r <= 1'b1; // R14
    else if (startDet || gst_r != GEN_IDLE) relScl_r <= 1'b0;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sclOut <= 1'b0;
      sclOe  <= 1'b0;
      sdaOut <= 1'b0;
      sdaOe  <= 1'b0;
    end else begin
      sclOut <= 1'b0;
      sdaOut <= 1'b0;
      if (!active) begin
        sclOe <= 1'b0;
        sdaOe <= 1'b0;
      end else if (gst_r != GEN_IDLE) begin
        sclOe <= ~gScl_r;
        sdaOe <= ~gSda_r;
      end else begin
        sclOe <= smB_r[SMB_FLOW] | holdLow_r | startHold_r | // R15
                 (~intScl_r & ~relScl_r); // R14
        sdaOe <= (~dataDly | startHold_r) & ~smB_r[SMB_DOD] & // R19
                 ~(smB_r[SMB_ALS] & alost_r); // R10
      end
    end
  end
  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  AST_PER_BIT: assert property (@(posedge clk) disable iff (!rst_n) // R7
    (active && xRise && sdaOe && !smA_r[SMA_ABC] && txBit != sdaPin &&
     !regWr) |=> alost_r)
    else $error("per-bit loss not flagged");
  AST_LOSS_STOP: assert property (@(posedge clk) disable iff (!rst_n) // R10
    (active && alost_r && smB_r[SMB_ALS] && gst_r == GEN_IDLE)
    |=> !sdaOe)
    else $error("data driven after loss");
  AST_DOD: assert property (@(posedge clk) disable iff (!rst_n) // R19
    (active && smB_r[SMB_DOD] && gst_r == GEN_IDLE) |=> !sdaOe)
    else $error("data driven while disabled");
  AST_FORCE: assert property (@(posedge clk) disable iff (!rst_n) // R15
    (active && smB_r[SMB_FLOW] && gst_r == GEN_IDLE) |=> sclOe)
    else $error("clock not forced low");
  AST_INACTIVE: assert property (@(posedge clk) disable iff (!rst_n) // R1
    !active |=> !sclOe && !sdaOe)
    else $error("pins driven outside mode");
  AST_STC: assert property (@(posedge clk) disable iff (!rst_n) // R23
    stcLoad |=> smB_r[SMB_WAIT] && bitCnt_r == 4'h0)
    else $error("start reset incomplete");
  AST_ACK: assert property (@(posedge clk) disable iff (!rst_n) // R22
    (ninthDone_r && !smB_r[SMB_LAYOUT])
    |=> (events.ack ^ events.nack) && dmaReq == events.ack)
    else $error("ack event missing");
  AST_WAIT: assert property (@(posedge clk) disable iff (!rst_n) // R13
    (active && byteEnd && smB_r[SMB_WAIT] && !stopDet &&
     gst_r == GEN_IDLE) |=> holdLow_r ##1 sclOe)
    else $error("clock wait not held");
endmodule

// file: testbench/twi_bus_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Two-wire bus with pull-ups and one outside master
// ---------------------------------------------------------------
module twi_bus_model (
  input  wire logic dutSclOe,
  input  wire logic dutSdaOe,
  output logic      sclLine,
  output logic      sdaLine
);
  logic extSclLow = 1'b0;
  logic extSdaLow = 1'b0;
  int   staSeen   = 0;
  int   stoSeen   = 0;

  // Wired AND; a released line floats back high, never holds a value
  assign sclLine = !(extSclLow || dutSclOe);
  assign sdaLine = !(extSdaLow || dutSdaOe);

  // Wire-level watch of conditions, whoever makes them
  always @(negedge sdaLine) if (sclLine === 1'b1) staSeen++;
  always @(posedge sdaLine) if (sclLine === 1'b1) stoSeen++;

  // Outside master, 48 ns bit period; clock stands still between frames
  task sendStart();
    #12 extSdaLow = 1'b1;
    #12 extSclLow = 1'b1;
  endtask

  // Data changes only while the clock is low
  task sendBit(input logic b);
    extSdaLow = !b;
    #12 extSclLow = 1'b0;
    #24 extSclLow = 1'b1;
    #12;
  endtask

  // Eight bits MSB first, then the ninth
  task sendByte(input logic [7:0] d, input logic ninth);
    for (int i = 7; i >= 0; i--) sendBit(d[i]);
    sendBit(ninth);
  endtask

  task sendStop();
    extSdaLow = 1'b1;
    #12 extSclLow = 1'b0;
    #12 extSdaLow = 1'b0;
    #24;
  endtask
endmodule

// file: testbench/twi_unit_tb_top.sv
`timescale 1ns/1ps
module twi_unit_tb_top
  import twi_pkg::*;
;
  logic        clk      = 1'b0;
  logic        rst_n    = 1'b0;
  logic [4:0]  regAddr  = 5'h00;
  logic [15:0] regWdata = 16'h0000;
  logic        regWr    = 1'b0;
  logic        regRd    = 1'b0;
  logic [15:0] regRdata;
  logic        sclOe;
  logic        sdaOe;
  logic        sclLine;
  logic        sdaLine;
  logic        dmaReq;
  event_type   events;
  logic [15:0] rdv;
  int          fails     = 0;
  int          cmp_count = 0;
  int          condCnt   = 0;
  int          ackCnt    = 0;
  int          nackCnt   = 0;
  int          dmaCnt    = 0;
  int          b;
  int          d;

  // ---------------------------------------------------------------
  // Clock, design and bus
  // ---------------------------------------------------------------
  initial begin
    forever #2.5 clk = !clk;
  end

  twi_unit i_dut (
    .clk      (clk),
    .rst_n    (rst_n),
    .regAddr  (regAddr),
    .regWdata (regWdata),
    .regWr    (regWr),
    .regRd    (regRd),
    .regRdata (regRdata),
    .sclIn    (sclLine),
    .sclOut   (),
    .sclOe    (sclOe),
    .sdaIn    (sdaLine),
    .sdaOut   (),
    .sdaOe    (sdaOe),
    .events   (events),
    .dmaReq   (dmaReq)
  );

  twi_bus_model i_bus (
    .dutSclOe (sclOe),
    .dutSdaOe (sdaOe),
    .sclLine  (sclLine),
    .sdaLine  (sdaLine)
  );

  // Pulses last one cycle, so count them rather than poll
  always @(posedge clk) begin
    if (events.condition === 1'b1) condCnt++;
    if (events.ack === 1'b1) ackCnt++;
    if (events.nack === 1'b1) nackCnt++;
    if (dmaReq === 1'b1) dmaCnt++;
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task check(logic [15:0] seen, logic [15:0] exp, string msg);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %0t %s", $time, msg);
    end
  endtask

  task wr(logic [4:0] a, logic [15:0] d);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clk);
    regWr    <= 1'b0;
  endtask

  // Data stand from the cycle after the strobe until the next read
  task rd(logic [4:0] a);
    @(posedge clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd   <= 1'b0;
    #1 rdv = regRdata;
  endtask

  task automatic waitCnt(ref int c, input int base);
    for (int i = 0; i < 400 && c == base; i++) @(posedge clk);
  endtask

  task finish_test();
    if (fails == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task t_reset();
    for (int a = 0; a < 8; a++) begin
      rd(5'(a * 4));
      check(rdv, 16'h0000, "reset value");
    end
    rd(5'h01);
    check(rdv, 16'h0000, "unmapped read");
    check({14'h0000, sclOe, sdaOe}, 16'h0000, "pins idle");
  endtask

  // Mode off: conditions on the wire must be ignored
  task t_gate();
    b = condCnt;
    i_bus.sendStart();
    waitCnt(condCnt, b);
    check(16'(condCnt - b), 16'h0000, "event while off");
    i_bus.sendStop();
    check({14'h0000, sclOe, sdaOe}, 16'h0000, "pins while off");
  endtask

  task t_receive();
    // All ones to send keeps the data line released while listening
    wr(ADDR_TXBUF, 16'h00FF);
    wr(ADDR_MODE, 16'(MODE_TWO_WIRE));
    wr(ADDR_SMA, 16'h0001 << SMA_SEL);
    b = condCnt;
    i_bus.sendStart();
    waitCnt(condCnt, b);
    check(16'(condCnt - b), 16'h0001, "start event");
    rd(ADDR_SMA);
    check(rdv & (16'h0001 << SMA_BUSY), 16'h0004, "busy set");
    b = nackCnt;
    d = dmaCnt;
    i_bus.sendByte(8'hA5, 1'b1);
    waitCnt(nackCnt, b);
    check(16'(nackCnt - b), 16'h0001, "nack event");
    check(16'(dmaCnt - d), 16'h0000, "dma with nack");
    rd(ADDR_RXBUF);
    check(rdv & 16'h01FF, 16'h01A5, "layout zero");
    wr(ADDR_RXBUF, 16'h0000);
    b = ackCnt;
    d = dmaCnt;
    i_bus.sendByte(8'h3C, 1'b0);
    waitCnt(ackCnt, b);
    check(16'(ackCnt - b), 16'h0001, "ack event");
    check(16'(dmaCnt - d), 16'h0001, "dma with ack");
    rd(ADDR_RXBUF);
    check(rdv & 16'h01FF, 16'h003C, "layout zero ack");
    wr(ADDR_SMB, 16'h0001 << SMB_LAYOUT);
    i_bus.sendByte(8'hA5, 1'b0);
    repeat (20) @(posedge clk);
    rd(ADDR_RXBUF);
    check(rdv & 16'h017F, 16'h0152, "layout one");
    wr(ADDR_SMB, 16'h0000);
    b = condCnt;
    i_bus.sendStop();
    waitCnt(condCnt, b);
    check(16'(condCnt - b), 16'h0001, "stop event");
    rd(ADDR_SMA);
    check(rdv & (16'h0001 << SMA_BUSY), 16'h0000, "busy clear");
  endtask

  // Start with reset enabled arms the ninth-bit clock hold
  task t_hold();
    wr(ADDR_SMB, 16'h0001 << SMB_STC);
    b = condCnt;
    i_bus.sendStart();
    waitCnt(condCnt, b);
    rd(ADDR_SMB);
    check(rdv & (16'h0001 << SMB_WAIT), 16'h0004, "wait armed");
    i_bus.sendByte(8'h55, 1'b1);
    repeat (10) @(posedge clk);
    check({15'h0000, sclOe}, 16'h0001, "clock held");
    wr(ADDR_SMB, 16'h0000);
    repeat (10) @(posedge clk);
    check({15'h0000, sclOe}, 16'h0000, "clock freed");
    wr(ADDR_SMB, 16'h0001 << SMB_FLOW);
    repeat (4) @(posedge clk);
    check({15'h0000, sclOe}, 16'h0001, "clock forced low");
    wr(ADDR_SMB, 16'h0000);
    repeat (4) @(posedge clk);
    check({15'h0000, sclOe}, 16'h0000, "clock force lifted");
    b = condCnt;
    i_bus.sendStop();
    waitCnt(condCnt, b);
  endtask

  // Generated conditions; phases kept short through the reload value
  task t_generate();
    int s;
    wr(ADDR_BAUD, 16'h0004);
    s = i_bus.staSeen;
    b = condCnt;
    wr(ADDR_SMD, 16'h0001 << SMD_STA);
    wr(ADDR_SMD, (16'h0001 << SMD_STA) | (16'h0001 << SMD_GEN));
    waitCnt(condCnt, b);
    check(16'(i_bus.staSeen - s), 16'h0001, "start on wire");
    check(16'(condCnt - b), 16'h0001, "start done event");
    rd(ADDR_SMD);
    check(rdv & 16'h0001, 16'h0000, "start bit cleared");
    check({14'h0000, sclOe, sdaOe}, 16'h0003, "held after start");
    wr(ADDR_SMB, 16'h0001 << SMB_DOD);
    repeat (4) @(posedge clk);
    check({15'h0000, sdaOe}, 16'h0000, "data disabled");
    wr(ADDR_SMB, 16'h0000);
    repeat (4) @(posedge clk);
    check({15'h0000, sdaOe}, 16'h0001, "data disable lifted");
    s = i_bus.stoSeen;
    b = condCnt;
    wr(ADDR_SMD, (16'h0001 << SMD_STP) | (16'h0001 << SMD_GEN));
    waitCnt(condCnt, b);
    check(16'(i_bus.stoSeen - s), 16'h0001, "stop on wire");
    check(16'(condCnt - b), 16'h0001, "stop done event");
  endtask

  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_gate();
    t_receive();
    t_hold();
    t_generate();
    finish_test();
  end

  // Whole run needs well under a tenth of this span
  initial begin
    #200000;
    fails++;
    finish_test();
  end
endmodule
